// [common/sled_if.sv]
// Purpose: Two-wire link between data source and LED driver.
// Assumes: Both ends on one system clock; the driver still synchronises.
// Notes: No load or select line exists.
`timescale 1ns/10ps
`default_nettype none
interface sled_if;
	logic sclk;
	logic sdata;
	modport source (output sclk, output sdata);
	modport driver (input sclk, input sdata);
endinterface : sled_if
`default_nettype wire

// [common/sled_pkg.sv]
// Purpose: Shared constants for the serial LED segment driver link.
// Assumes: 20 MHz system clock on both ends.
// Notes: Frame is one start bit plus 35 data bits, 36 clocks in all.
package sled_pkg;
	localparam int FRAME_BITS = 35;
	localparam int FRAME_CLOCKS = 36;
	localparam int SEG_COUNT = 15;
	localparam int CNT_W = 6;
	localparam logic [5:0] LAST_CLOCK = 6'h23;
	localparam int CLK_NS = 50;
	// Least serial clock period: 0.5 MHz gives 2000 ns
	localparam int SCLK_PERIOD_NS = 2000;
	localparam int HALF_CYCLES = (SCLK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
	localparam int HALF_W = 8;
	// Frame bit position (1..35) feeding each output 1..15
	localparam logic [5:0] SEG_BIT [SEG_COUNT] = '{
		6'h05, 6'h06, 6'h07, 6'h08, 6'h0d, 6'h0e, 6'h0f, 6'h10,
		6'h15, 6'h16, 6'h17, 6'h18, 6'h1d, 6'h1e, 6'h23};
	typedef enum logic [1:0] {SLED_IDLE, SLED_LOW, SLED_HIGH} sled_tx_state_t;
endpackage : sled_pkg

// [design/sled_driver.sv]
// Purpose: Device end: shifts 36-clock frames and latches 15 segment outputs.
// Assumes: Link clock sampled through three flops; rst stands for power-on.
// Notes: Edges of the link clock are detected once two late stages agree.
`timescale 1ns/10ps
`default_nettype none
module sled_driver (
	input wire logic clk,
	input wire logic rst,
	sled_if.driver link,
	output logic [sled_pkg::SEG_COUNT-1:0] seg_on
);
	logic [2:0] sclk_sync;
	logic [2:0] data_sync;
	logic sclk_state;
	logic data_lvl;
	logic [sled_pkg::FRAME_CLOCKS-1:0] shift;
	logic first_master;
	logic [sled_pkg::CNT_W-1:0] count;
	logic load_done;
	logic rise;
	logic fall;

	// Three-flop synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_sync <= 3'h0;
			data_sync <= 3'h0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], link.sclk};
			data_sync <= {data_sync[1:0], link.sdata};
		end
	end

	// A change counts only when stages 1 and 2 agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_state <= 1'b0;
			data_lvl <= 1'b0;
		end else begin
			if (sclk_sync[1] == sclk_sync[2]) begin
				sclk_state <= sclk_sync[2];
			end
			if (data_sync[1] == data_sync[2]) begin
				data_lvl <= data_sync[2];
			end
		end
	end

	assign rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_state;
	assign fall = (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2] && sclk_state;

	// Master of first stage samples data on every rising edge, cleared only by reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_master <= 1'b0;
		end else if (rise) begin
			first_master <= data_lvl;
		end
	end

	// Clock counter; frame starts with the start bit in the first stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (fall && load_done) begin
			count <= '0;
		end else if (rise && (count != '0 || data_lvl)) begin
			count <= count + 6'h01;
		end
	end

	// Shift stages: slaves update on the rising edge, cleared after load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift <= '0;
		end else if (fall && load_done) begin
			shift <= '0;
		end else if (rise) begin
			shift <= {shift[sled_pkg::FRAME_CLOCKS-2:0], data_lvl};
		end
	end

	// Load flag marks the 36th high phase until its following low phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_done <= 1'b0;
		end else if (fall) begin
			load_done <= 1'b0;
		end else if (rise && count == sled_pkg::LAST_CLOCK) begin
			load_done <= 1'b1;
		end
	end

	// Output latches: loaded on the 36th rising edge only, otherwise hold.
	// Shift index: after 36 edges, frame bit k sits at shift[35-k]+... computed here
	// as the new shift word, with the start bit at the top.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seg_on <= '0;
		end else if (rise && count == sled_pkg::LAST_CLOCK) begin
			for (int i = 0; i < sled_pkg::SEG_COUNT; i++) begin
				// Frame bit b arrived b edges after start: it now sits at index 35-b
				seg_on[i] <= load_bit(shift, data_lvl, sled_pkg::SEG_BIT[i]);
			end
		end // Else latches hold
	end

	// Picks frame bit b from the word as it stands after this edge
	function automatic logic load_bit(input logic [sled_pkg::FRAME_CLOCKS-1:0] sr, input logic din,
		input logic [5:0] b);
		logic [sled_pkg::FRAME_CLOCKS-1:0] nxt;
		nxt = {sr[sled_pkg::FRAME_CLOCKS-2:0], din};
		load_bit = nxt[sled_pkg::LAST_CLOCK - b];
	endfunction : load_bit
endmodule : sled_driver
`default_nettype wire

// [design/sled_source.sv]
// Purpose: Source end: sends one 36-clock frame per request.
// Assumes: 20 MHz clock; link clock half period is a whole cycle count.
// Notes: Busy stays high until one cycle after the last high phase ends; no low phase follows it.
`timescale 1ns/10ps
`default_nettype none
module sled_source #(
	parameter int HALF = sled_pkg::HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic send,
	input wire logic [sled_pkg::FRAME_BITS-1:0] frame,
	output logic busy,
	sled_if.source link
);
	sled_pkg::sled_tx_state_t state;
	logic [sled_pkg::FRAME_CLOCKS-1:0] word;
	logic [sled_pkg::CNT_W-1:0] bits;
	logic [sled_pkg::HALF_W-1:0] tick;
	logic sclk_q;
	logic sdata_q;

	assign link.sclk = sclk_q;
	assign link.sdata = sdata_q;

	// Half-period divider; rate at or below 0.5 MHz only when HALF is 20 or more, as by default
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick <= '0;
		end else if (state == sled_pkg::SLED_IDLE || tick == sled_pkg::HALF_W'(HALF - 1)) begin
			tick <= '0;
		end else begin
			tick <= tick + 8'h01;
		end
	end

	// Frame sequencer: start bit, then bit 1 up to bit 35, full 36 clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= sled_pkg::SLED_IDLE;
			word <= '0;
			bits <= '0;
			sclk_q <= 1'b0;
			sdata_q <= 1'b0;
			busy <= 1'b0;
		end else begin
			case (state)
				sled_pkg::SLED_IDLE: begin
					sclk_q <= 1'b0;
					if (send) begin
						word <= {frame, 1'b1};
						sdata_q <= 1'b1;
						bits <= '0;
						busy <= 1'b1;
						state <= sled_pkg::SLED_LOW;
					end else begin
						busy <= 1'b0;
					end
				end
				sled_pkg::SLED_LOW: begin
					if (tick == sled_pkg::HALF_W'(HALF - 1)) begin
						sclk_q <= 1'b1;
						bits <= bits + 6'h01;
						state <= sled_pkg::SLED_HIGH;
					end
				end
				sled_pkg::SLED_HIGH: begin
					if (tick == sled_pkg::HALF_W'(HALF - 1)) begin
						sclk_q <= 1'b0;
						word <= {1'b0, word[sled_pkg::FRAME_CLOCKS-1:1]};
						sdata_q <= word[1];
						// Ends only after the full count of clocks, start bit included
						if (bits == sled_pkg::CNT_W'(sled_pkg::FRAME_CLOCKS)) begin
							state <= sled_pkg::SLED_IDLE;
						end else begin
							state <= sled_pkg::SLED_LOW;
						end
					end
				end
				default: state <= sled_pkg::SLED_IDLE;
			endcase
		end
	end
endmodule : sled_source
`default_nettype wire

// [verification/serial_led_segment_driver_test.sv]
// Purpose: Bench for the serial LED link.
// Assumes: HALF of 4; link_b is driven by hand.
// Notes: Outputs are judged mid-frame and after each sent frame ends; the first hand-made frame is not judged on its own.
`timescale 1ns/10ps
`default_nettype none
module serial_led_segment_driver_test;
	localparam int POS [15] = '{5, 6, 7, 8, 13, 14, 15, 16, 21, 22, 23, 24, 29, 30, 35};
	logic clk = 1'b0, rst = 1'b1, send = 1'b0, busy;
	logic [34:0] frame = 35'h0_0000_0000;
	logic [14:0] seg_on, seg_b, last;
	int fails = 0, samples_checked = 0;
	sled_if link ();
	sled_if link_b ();
	sled_source #(.HALF(4)) sled_source_inst (.clk(clk), .rst(rst), .send(send), .frame(frame), .busy(busy), .link(link));
	sled_driver sled_driver_inst (.clk(clk), .rst(rst), .link(link), .seg_on(seg_on));
	sled_driver sled_driver_inst_b (.clk(clk), .rst(rst), .link(link_b), .seg_on(seg_b));
	sled_checker sled_checker_inst (.clk(clk), .rst(rst), .sclk(link.sclk), .sdata(link.sdata),
		.busy(busy), .seg_on(seg_on));
	// 20 MHz clock
	always #25 clk = ~clk;
	function automatic logic [14:0] segs(input logic [34:0] f);
		for (int i = 0; i < 15; i++) segs[i] = f[POS[i] - 1];
	endfunction : segs
	task automatic results();
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	task automatic check(input logic [14:0] seen, input logic [14:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t segment mismatch", $time);
		end
	endtask : check
	// Bounded wait, so a stuck source ends the run
	task automatic wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 400 && busy !== lvl; i++) @(posedge clk);
		if (busy !== lvl) begin
			fails++;
			results();
		end
	endtask : wait_busy
	task automatic tx(input logic [34:0] f);
		last = seg_on;
		send <= 1'b1;
		frame <= f;
		wait_busy(1'b1);
		send <= 1'b0;
		repeat (100) @(posedge clk);
		check(seg_on, last);
		wait_busy(1'b0);
		repeat (4) @(posedge clk);
		check(seg_on, segs(f));
	endtask : tx
	// Hand-made link clocks; lets a frame be cut short
	task automatic raw(input int n, input logic [35:0] bits);
		for (int i = 0; i < n; i++) begin
			link_b.sdata <= bits[i];
			repeat (4) @(posedge clk);
			link_b.sclk <= 1'b1;
			repeat (4) @(posedge clk);
			link_b.sclk <= 1'b0;
		end
	endtask : raw
	initial begin
		link_b.sclk = 1'b0;
		link_b.sdata = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		check(seg_on, 15'h0000);
		check(seg_b, 15'h0000);
		for (int k = 0; k < 15; k++) tx(35'h0_0000_0001 << (POS[k] - 1));
		tx(35'h7_ffff_ffff);
		tx(~35'h4_30f0_f0f0);
		raw(36, {35'h0_0000_0010, 1'b1});
		raw(36, {35'h4_0000_0000, 1'b1});
		repeat (8) @(posedge clk);
		check(seg_b, 15'h4000);
		raw(20, {35'h7_ffff_ffff, 1'b1});
		repeat (8) @(posedge clk);
		check(seg_b, 15'h4000);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		check(seg_b, 15'h0000);
		raw(36, {35'h0_0000_0010, 1'b1});
		repeat (8) @(posedge clk);
		check(seg_b, 15'h0001);
		results();
	end
endmodule : serial_led_segment_driver_test
`default_nettype wire

// [verification/sled_checker.sv]
// Purpose: Link and segment checks.
// Assumes: Source built with HALF of 4.
// Notes: Segments may change only once 36 rises are counted.
`timescale 1ns/10ps
`default_nettype none
module sled_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic busy,
	input wire logic [14:0] seg_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [5:0] n;
	// Rises in this frame, cleared while idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) n <= 6'h00;
		else if (!busy) n <= 6'h00;
		else if ($rose(sclk)) n <= n + 6'h01;
	end
	property p_idle; !busy |-> !sclk; endproperty
	a_idle: assert property (p_idle) else $error("clock moves while idle");
	property p_start; $rose(busy) |-> sdata ##0 !sclk[*4] ##1 sclk; endproperty
	a_start: assert property (p_start) else $error("bad start bit");
	property p_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
	a_high: assert property (p_high) else $error("bad high phase");
	property p_low; $fell(sclk) && n != 6'h24 |-> !sclk[*4] ##1 sclk; endproperty
	a_low: assert property (p_low) else $error("bad low phase");
	property p_stable; sclk |-> $stable(sdata); endproperty
	a_stable: assert property (p_stable) else $error("data moved");
	property p_count; $fell(busy) |-> n == 6'h24; endproperty
	a_count: assert property (p_count) else $error("frame length");
	property p_load; $changed(seg_on) |-> n == 6'h24; endproperty
	a_load: assert property (p_load) else $error("early load");
	property p_por; $fell(rst) |-> seg_on == 15'h0000; endproperty
	a_por: assert property (p_por) else $error("reset value");
	c_start: cover property ($rose(busy));
	c_end: cover property ($fell(busy));
	c_load: cover property ($changed(seg_on));
endmodule : sled_checker
`default_nettype wire
